// >>> pkg/tap_pkg.sv
package tap_pkg;

  // ----------------------------------------------------------------
  // sizes and codes
  // ----------------------------------------------------------------
  localparam int IR_LEN  = 3;
  localparam int ID_LEN  = 32;
  localparam int BSR_LEN = 16;

  localparam logic [IR_LEN-1:0] IR_EXTEST   = 3'h0;
  localparam logic [IR_LEN-1:0] IR_IDCODE   = 3'h1;
  localparam logic [IR_LEN-1:0] IR_SAMPLE_Z = 3'h2;
  localparam logic [IR_LEN-1:0] IR_SAMPLE   = 3'h4;

  // identification value is arbitrary; bit 0 set as boundary scan expects
  localparam logic [ID_LEN-1:0] ID_VALUE = 32'h0000_0001;

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET      = 4'b0000,
    ST_IDLE       = 4'b0001,
    ST_SEL_DR     = 4'b0010,
    ST_CAPTURE_DR = 4'b0011,
    ST_SHIFT_DR   = 4'b0100,
    ST_EXIT1_DR   = 4'b0101,
    ST_PAUSE_DR   = 4'b0110,
    ST_EXIT2_DR   = 4'b0111,
    ST_UPDATE_DR  = 4'b1000,
    ST_SEL_IR     = 4'b1001,
    ST_CAPTURE_IR = 4'b1010,
    ST_SHIFT_IR   = 4'b1011,
    ST_EXIT1_IR   = 4'b1100,
    ST_PAUSE_IR   = 4'b1101,
    ST_EXIT2_IR   = 4'b1110,
    ST_UPDATE_IR  = 4'b1111
  } tap_state_t;

  // ----------------------------------------------------------------
  // pin groups
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tap_pins_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } tap_out_t;

endpackage

// >>> logic/scan_chain.sv
module scan_chain (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  // controls, one-cycle enables
  input  wire logic                        capture_en,
  input  wire logic                        shift_en,
  input  wire logic                        update_en,
  // serial path
  input  wire logic                        scan_in,
  output logic                             scan_out,
  // parallel ring
  input  wire logic [tap_pkg::BSR_LEN-1:0] par_in,
  output logic [tap_pkg::BSR_LEN-1:0]      par_out
);
  import tap_pkg::*;

  logic [BSR_LEN-1:0] chain;
  logic [BSR_LEN-1:0] next_chain;

  assign next_chain = capture_en ? par_in
                    : shift_en   ? {scan_in, chain[BSR_LEN-1:1]}
                    : chain;
  assign scan_out   = chain[0];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      chain   <= '0;
      par_out <= '0;
    end else begin
      chain <= next_chain;
      // update latch keeps pin values steady while shifting
      if (update_en) begin
        par_out <= chain;
      end
    end
  end

endmodule

// >>> logic/memory_test_port.sv
// Operation
// - controller state moves only on detected rising edges of test clock.
// - mode select is sampled on each rising test clock edge.
// - data input sampled into selected scan register on rising edge.
// - data output updated from selected register on falling edge.
// - one controller, one instruction register, several data registers.
// - memory keeps running except under external test or sample-z.
// - only a subset: controller, boundary scan, identification, bypass.
// - reset state at power up or after five ones on mode select.
// - three-bit instruction, 001 at reset and capture, acts on update.
// - data input used and output enabled only in shift states.
// - codes 000 extest, 001 id, 010 sample-z, 100 sample; others reserved.
module memory_test_port (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  // test port pins
  input  wire tap_pkg::tap_pins_t          pins,
  output tap_pkg::tap_out_t                tap_out,
  // boundary ring
  input  wire logic [tap_pkg::BSR_LEN-1:0] ring_in,
  output logic [tap_pkg::BSR_LEN-1:0]      ring_out,
  output logic                             ring_drive,
  // memory core controls
  output logic                             dq_force_off,
  output logic                             odt_disable,
  output logic                             core_enable
);
  import tap_pkg::*;

  // ----------------------------------------------------------------
  // next state of the controller
  // ----------------------------------------------------------------
  function automatic tap_state_t tap_next(input tap_state_t s,
                                          input logic tms);
    tap_state_t n;
    n = ST_RESET;
    case (s)
      ST_RESET:      n = tms ? ST_RESET     : ST_IDLE;
      ST_IDLE:       n = tms ? ST_SEL_DR    : ST_IDLE;
      ST_SEL_DR:     n = tms ? ST_SEL_IR    : ST_CAPTURE_DR;
      ST_CAPTURE_DR: n = tms ? ST_EXIT1_DR  : ST_SHIFT_DR;
      ST_SHIFT_DR:   n = tms ? ST_EXIT1_DR  : ST_SHIFT_DR;
      ST_EXIT1_DR:   n = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR:   n = tms ? ST_EXIT2_DR  : ST_PAUSE_DR;
      ST_EXIT2_DR:   n = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR:  n = tms ? ST_SEL_DR    : ST_IDLE;
      ST_SEL_IR:     n = tms ? ST_RESET     : ST_CAPTURE_IR;
      ST_CAPTURE_IR: n = tms ? ST_EXIT1_IR  : ST_SHIFT_IR;
      ST_SHIFT_IR:   n = tms ? ST_EXIT1_IR  : ST_SHIFT_IR;
      ST_EXIT1_IR:   n = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR:   n = tms ? ST_EXIT2_IR  : ST_PAUSE_IR;
      ST_EXIT2_IR:   n = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR:  n = tms ? ST_SEL_DR    : ST_IDLE;
      default:       n = ST_RESET;
    endcase
    return n;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and test clock edges
  // ----------------------------------------------------------------
  // all three pins see the same delay so tms/tdi stay aligned to tck
  tap_pins_t  pins_meta;
  tap_pins_t  pins_sync;
  logic       tck_prev;
  wire        tck_rise = pins_sync.tck & ~tck_prev;
  wire        tck_fall = ~pins_sync.tck & tck_prev;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pins_meta <= '0;
      pins_sync <= '0;
      tck_prev  <= 1'b0;
    end else begin
      pins_meta <= pins;
      pins_sync <= pins_meta;
      tck_prev  <= pins_sync.tck;
    end
  end

  // ----------------------------------------------------------------
  // controller
  // ----------------------------------------------------------------
  tap_state_t state;
  tap_state_t next_state;

  // five ones on tms reach reset from any state through the table
  assign next_state = tap_next(state, pins_sync.tms);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= ST_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // state decode; capture, shift and update strobes qualified by the rising edge
  // ----------------------------------------------------------------
  wire in_reset    = (state == ST_RESET);
  wire in_shift_ir = (state == ST_SHIFT_IR);
  wire in_shift_dr = (state == ST_SHIFT_DR);
  wire cap_ir      = tck_rise & (state == ST_CAPTURE_IR);
  wire sh_ir       = tck_rise & in_shift_ir;
  wire upd_ir      = tck_rise & (state == ST_UPDATE_IR);
  wire cap_dr      = tck_rise & (state == ST_CAPTURE_DR);
  wire sh_dr       = tck_rise & in_shift_dr;
  wire upd_dr      = tck_rise & (state == ST_UPDATE_DR);
  wire tdi_bit     = pins_sync.tdi;

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  logic [IR_LEN-1:0] ir_shift;
  logic [IR_LEN-1:0] ir;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ir_shift <= IR_IDCODE;
      ir       <= IR_IDCODE;
    end else if (in_reset) begin
      // reload while parked in reset: tck may stop right after entry
      ir_shift <= IR_IDCODE;
      ir       <= IR_IDCODE;
    end else begin
      if (cap_ir) begin
        ir_shift <= IR_IDCODE;
      end else if (sh_ir) begin
        ir_shift <= {tdi_bit, ir_shift[IR_LEN-1:1]};
      end
      // a shifted code only takes effect here
      if (upd_ir) begin
        ir <= ir_shift;
      end
    end
  end

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  wire is_extest   = (ir == IR_EXTEST);
  wire is_idcode   = (ir == IR_IDCODE);
  wire is_sample_z = (ir == IR_SAMPLE_Z);
  wire is_sample   = (ir == IR_SAMPLE);
  // reserved codes fall back to the one-bit bypass path
  wire sel_bsr     = is_extest | is_sample_z | is_sample;
  wire sel_bypass  = ~(sel_bsr | is_idcode);

  // ----------------------------------------------------------------
  // data registers: identification, bypass, boundary scan
  // ----------------------------------------------------------------
  logic [ID_LEN-1:0] id_shift;
  logic              bypass;
  logic              bsr_out;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      id_shift <= ID_VALUE;
      bypass   <= 1'b0;
    end else begin
      if (cap_dr & is_idcode) begin
        id_shift <= ID_VALUE;
      end else if (sh_dr & is_idcode) begin
        id_shift <= {tdi_bit, id_shift[ID_LEN-1:1]};
      end
      if (cap_dr & sel_bypass) begin
        bypass <= 1'b0;
      end else if (sh_dr & sel_bypass) begin
        bypass <= tdi_bit;
      end
    end
  end

  scan_chain u_bsr (
    .clk        (clk),
    .reset_n    (reset_n),
    .capture_en (cap_dr & sel_bsr),
    .shift_en   (sh_dr & sel_bsr),
    .update_en  (upd_dr & sel_bsr),
    .scan_in    (tdi_bit),
    .scan_out   (bsr_out),
    .par_in     (ring_in),
    .par_out    (ring_out)
  );

  // ----------------------------------------------------------------
  // serial output, changed on the falling edge
  // ----------------------------------------------------------------
  wire dr_bit  = is_idcode ? id_shift[0]
               : sel_bsr   ? bsr_out
               : bypass;
  wire out_bit = in_shift_ir ? ir_shift[0] : dr_bit;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tap_out <= '0;
    end else if (tck_fall) begin
      tap_out.tdo    <= out_bit;
      tap_out.tdo_oe <= in_shift_ir | in_shift_dr;
    end
  end

  // ----------------------------------------------------------------
  // effect on the memory core
  // ----------------------------------------------------------------
  // held registered so the core never sees decode glitches
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ring_drive   <= 1'b0;
      dq_force_off <= 1'b0;
      odt_disable  <= 1'b0;
      core_enable  <= 1'b1;
    end else begin
      ring_drive   <= is_extest;
      dq_force_off <= is_sample_z;
      odt_disable  <= is_extest | is_sample_z;
      core_enable  <= ~(is_extest | is_sample_z);
    end
  end

endmodule

// >>> tb/tap_chk.sv
module tap_chk (
  // clock and reset
  input wire logic                        clk,
  input wire logic                        reset_n,
  // watched ports
  input wire tap_pkg::tap_pins_t          pins,
  input wire tap_pkg::tap_out_t           tap_out,
  input wire logic [tap_pkg::BSR_LEN-1:0] ring_out,
  input wire logic                        ring_drive,
  input wire logic                        dq_force_off,
  input wire logic                        odt_disable,
  input wire logic                        core_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  import tap_pkg::*;
  // ------------------------------------------------------------
  // port timing
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_tck_high2;
    pins.tck ##1 pins.tck;
  endsequence
  property p_tdo_fall;
    $changed(tap_out.tdo) |-> !pins.tck && !$past(pins.tck, 2);
  endproperty
  property p_tdo_hold;
    s_tck_high2 |-> $stable(tap_out.tdo);
  endproperty
  property p_oe_fall;
    $changed(tap_out.tdo_oe) |-> !pins.tck && !$past(pins.tck, 2);
  endproperty
  property p_core_pair;
    core_enable == !odt_disable;
  endproperty
  property p_sample_z;
    dq_force_off |-> odt_disable && !ring_drive;
  endproperty
  property p_extest;
    ring_drive |-> odt_disable && !dq_force_off;
  endproperty
  property p_rst;
    $rose(reset_n) |-> core_enable && !ring_drive && !tap_out.tdo_oe
      && ring_out == '0;
  endproperty
  // outputs only move some edges after a detected tck rise
  property p_core_tck;
    $changed(core_enable) |-> $past(pins.tck, 3);
  endproperty
  property p_ring_tck;
    $changed(ring_out) |-> $past(pins.tck, 3);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall)
    else $error("tdo moved while tck high");
  a_tdo_hold: assert property (p_tdo_hold)
    else $error("tdo unstable while tck high");
  a_oe_fall: assert property (p_oe_fall)
    else $error("tdo enable moved while tck high");
  a_core_pair: assert property (p_core_pair)
    else $error("core enable and odt disable disagree");
  a_sample_z: assert property (p_sample_z)
    else $error("force off without odt disable");
  a_extest: assert property (p_extest)
    else $error("ring drive with wrong companions");
  a_rst: assert property (p_rst)
    else $error("outputs wrong after reset");
  a_core_tck: assert property (p_core_tck)
    else $error("core enable moved without tck rise");
  a_ring_tck: assert property (p_ring_tck)
    else $error("ring moved without tck rise");
endmodule

bind memory_test_port tap_chk chk (
  .clk(clk), .reset_n(reset_n), .pins(pins), .tap_out(tap_out),
  .ring_out(ring_out), .ring_drive(ring_drive),
  .dq_force_off(dq_force_off), .odt_disable(odt_disable),
  .core_enable(core_enable)
);

// >>> tb/tap_host.sv
module tap_host (
  // system clock
  input  wire logic clk,
  // test pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // external test controller
  // ------------------------------------------------------------
  int slow = 0;
  // idle: tck parked low so the port is never clocked
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one tck period; tdo is taken just before the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    repeat (4 + slow) @(negedge clk);
    o = tdo;
    tck = 1'b1;
    repeat (4) @(negedge clk);
    tck = 1'b0;
  endtask
  task automatic move(input logic [7:0] seq, input int n);
    logic o;
    for (int i = 0; i < n; i++)
      step(seq[i], 1'b1, o);
  endtask
  // lsb first, tms high on the last bit
  task automatic scan(input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
  endtask
endmodule

// >>> tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tap_pkg::*;
  // ------------------------------------------------------------
  // bench
  // ------------------------------------------------------------
  logic                clk;
  logic                reset_n;
  logic                tck;
  logic                tms;
  logic                tdi;
  logic                tdo_w;
  logic                tdo_last = 1'b0;
  tap_out_t            tap_out;
  logic [BSR_LEN-1:0]  ring_in;
  logic [BSR_LEN-1:0]  ring_out;
  logic                ring_drive;
  logic                dq_force_off;
  logic                odt_disable;
  logic                core_enable;
  int                  error_cnt = 0;
  int                  check_count = 0;
  int                  cycles = 0;

  memory_test_port uut (
    .clk(clk), .reset_n(reset_n), .pins({tck, tms, tdi}),
    .tap_out(tap_out), .ring_in(ring_in), .ring_out(ring_out),
    .ring_drive(ring_drive), .dq_force_off(dq_force_off),
    .odt_disable(odt_disable), .core_enable(core_enable)
  );
  tap_host host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_w));

  // released tdo has no pull: show the inverse of the last driven bit
  always @(posedge clk)
    if (tap_out.tdo_oe)
      tdo_last <= tap_out.tdo;
  assign tdo_w = tap_out.tdo_oe ? tap_out.tdo : ~tdo_last;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic dr_scan(input int n, input logic [31:0] din,
                         output logic [31:0] dout);
    host.move(8'h01, 3);
    host.scan(n, din, dout);
    host.move(8'h01, 2);
  endtask
  task automatic ir_load(input logic [2:0] code);
    logic [31:0] cap;
    host.move(8'h03, 4);
    host.scan(3, {29'h0, code}, cap);
    check(cap, 32'h1);
    host.move(8'h01, 2);
  endtask
  task automatic t_reset;
    reset_n = 1'b0;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    check({core_enable, ring_drive, dq_force_off, odt_disable,
           tap_out.tdo_oe, ring_out},
          {5'h10, 16'h0000});
    host.move(8'h00, 1);
  endtask
  task automatic t_idcode;
    logic [31:0] d;
    host.slow = 3;
    dr_scan(32, 32'h0, d);
    check(d, ID_VALUE);
    host.slow = 0;
  endtask
  // every code, reserved ones included, then its data path
  task automatic t_codes;
    logic [31:0] d;
    logic        bsr;
    for (int c = 0; c < 8; c++) begin
      bsr = (c == 0) || (c == 2) || (c == 4);
      ring_in = 16'h3C5A ^ 16'(c);
      ir_load(3'(c));
      check({ring_drive, dq_force_off, odt_disable, tap_out.tdo_oe},
            {c == 0, c == 2, c == 0 || c == 2, 1'b0});
      dr_scan(c == 1 ? 32 : (bsr ? 16 : 2), 32'hA5C3, d);
      check(d, c == 1 ? ID_VALUE : (bsr ? 32'(ring_in) : 32'h2));
      if (bsr)
        check(32'(ring_out), 32'hA5C3);
    end
  endtask
  // five ones from shift-dr, the longest way round to reset
  task automatic t_five;
    ir_load(3'h0);
    host.move(8'h01, 3);
    host.move(8'h0F, 4);
    repeat (2) @(negedge clk);
    check({core_enable, ring_drive}, 2'b01);
    host.move(8'h01, 1);
    repeat (2) @(negedge clk);
    check({core_enable, ring_drive}, 2'b10);
    host.move(8'h00, 1);
  endtask
  // sample scan split by a pause; pause must not shift
  task automatic t_pause;
    logic [31:0] d;
    ring_in = 16'h1234;
    ir_load(3'h4);
    check({core_enable, ring_drive}, 2'b10);
    host.move(8'h01, 3);
    host.scan(8, 32'h96, d);
    check(d, 32'h34);
    host.move(8'h02, 3);
    host.scan(8, 32'h69, d);
    check(d, 32'h12);
    host.move(8'h01, 2);
    check(32'(ring_out), 32'h6996);
  endtask

  initial begin
    ring_in = 16'h0000;
    t_reset();
    t_idcode();
    t_codes();
    t_pause();
    t_five();
    ir_load(3'h0);
    t_reset();
    close_out();
  end
endmodule
